// *** rtl/plim_defines.vh ***
/*
 * Constants for the port indicator mode block.
 * Assumes inclusion by bare name from the rtl folder.
 */
`ifndef PLIM_DEFINES_VH
`define PLIM_DEFINES_VH

// ----------------------------------------------------------------
// Indicator modes
// ----------------------------------------------------------------
`define PLIM_MODE0        2'h0
`define PLIM_MODE1        2'h1
`define PLIM_MODE2        2'h2
`define PLIM_MODE3        2'h3
`define PLIM_MODE_RST     2'h0

// ----------------------------------------------------------------
// Sequencer states and timing
// ----------------------------------------------------------------
`define PLIM_ST_RESET     2'h0
`define PLIM_ST_CAPTURE   2'h1
`define PLIM_ST_RUN       2'h2
`define PLIM_CLK_MHZ      10
`define PLIM_BLINK_MS     50
`define PLIM_BLINK_CYC    (`PLIM_BLINK_MS * 1000 * `PLIM_CLK_MHZ)
`define PLIM_LED_OFF      1'h1

`endif

// *** rtl/plim_port_led.v ***
/*
 * Port indicator driver: eight ports, three active-low indicators
 * each, mapping chosen by a mode strap captured at reset release.
 * Assumes status inputs come from other clock domains (PHY/MAC) and
 * the strap from a pin; all pass two flip-flops before use.
 */
// Operation
// - Strap 00/01/10/11 at reset selects indicator mode 0/1/2/3
// - After reset each port drives three active-low indicator outputs
// - Indicator 0: speed in modes 0 and 3, collision in mode 2
// - Indicator 2: collision in mode 0, 10Mb link activity in mode 2
// - Mode 3 indicator 2: on full duplex, blinks on collision
// - Indicator 3: link plus activity modes 0/3, 100Mb activity mode 2
`timescale 1ns/1ns
`include "plim_defines.vh"

module plim_port_led #(
   parameter PORTS     = 8,
   parameter BLINK_CYC = `PLIM_BLINK_CYC
) (
   // Clock and reset
   input  wire             clk_in,
   input  wire             rst_b_in,
   // Mode strap
   input  wire [1:0]       indicator_mode_strap_in,
   // Per-port status
   input  wire [PORTS-1:0] link_up_in,
   input  wire [PORTS-1:0] activity_in,
   input  wire [PORTS-1:0] speed_100_in,
   input  wire [PORTS-1:0] full_duplex_in,
   input  wire [PORTS-1:0] collision_in,
   // Indicator pins, active low
   output reg  [PORTS-1:0] port_indicator_zero_out,
   output reg  [PORTS-1:0] port_indicator_two_out,
   output reg  [PORTS-1:0] port_indicator_three_out,
   // Indicator pin enables
   output reg  [PORTS-1:0] port_indicator_oe_out,
   // Captured mode
   output reg  [1:0]       indicator_mode_out
);

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   localparam SW = 5 * PORTS + 2;

   reg  [SW-1:0] sync1_reg;
   reg  [SW-1:0] sync2_reg;
   wire [PORTS-1:0] link_s;
   wire [PORTS-1:0] act_s;
   wire [PORTS-1:0] spd_s;
   wire [PORTS-1:0] fdx_s;
   wire [PORTS-1:0] col_s;
   wire [1:0]       strap_s;

   // Two-stage synchroniser for pins
   // No reset here: only pin levels pass through, and the
   // sequencer spends two edges after release before the strap
   // is read, so the second stage has settled by then
   always @(posedge clk_in) begin
      sync1_reg <= {indicator_mode_strap_in, collision_in, full_duplex_in,
                    speed_100_in, activity_in, link_up_in};
      sync2_reg <= sync1_reg;
   end

   assign link_s  = sync2_reg[PORTS-1:0];
   assign act_s   = sync2_reg[2*PORTS-1:PORTS];
   assign spd_s   = sync2_reg[3*PORTS-1:2*PORTS];
   assign fdx_s   = sync2_reg[4*PORTS-1:3*PORTS];
   assign col_s   = sync2_reg[5*PORTS-1:4*PORTS];
   assign strap_s = sync2_reg[SW-1:SW-2];

   // ----------------------------------------------------------------
   // Mode capture sequencer
   // ----------------------------------------------------------------
   localparam ST_RESET   = `PLIM_ST_RESET;
   localparam ST_CAPTURE = `PLIM_ST_CAPTURE;
   localparam ST_RUN     = `PLIM_ST_RUN;

   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [1:0] mode_reg;
   reg [1:0] mode_next;

   // Wait for the strap to clear the synchroniser, then latch once
   // Later strap moves pass the synchroniser but are ignored until next reset
   always @* begin
      state_next = state_reg;
      mode_next  = mode_reg;
      case (state_reg)
         ST_RESET: begin
            state_next = ST_CAPTURE;
         end
         ST_CAPTURE: begin
            mode_next  = strap_s;
            state_next = ST_RUN;
         end
         ST_RUN: begin
            state_next = ST_RUN;
         end
         default: begin
            state_next = ST_RESET;
         end
      endcase
   end

   always @(posedge clk_in) begin
      if (!rst_b_in) begin
         state_reg <= ST_RESET;
         mode_reg  <= `PLIM_MODE_RST;
      end else begin
         state_reg <= state_next;
         mode_reg  <= mode_next;
      end
   end

   // ----------------------------------------------------------------
   // Collision blink timer
   // ----------------------------------------------------------------
   reg [31:0] blink_cnt_reg;
   reg        blink_reg;

   // Terminal count, held at counter width
   localparam [31:0] BLINK_LAST = BLINK_CYC - 1;

   // Free-running half-period toggle; one phase shared by all ports
   // so every mode 3 collision lamp flashes in step
   always @(posedge clk_in) begin
      if (!rst_b_in) begin
         blink_cnt_reg <= 32'h0;
         blink_reg     <= 1'h0;
      end else if (blink_cnt_reg >= BLINK_LAST) begin
         blink_cnt_reg <= 32'h0;
         blink_reg     <= ~blink_reg;
      end else begin
         blink_cnt_reg <= blink_cnt_reg + 32'h1;
      end
   end

   // ----------------------------------------------------------------
   // Indicator mapping
   // ----------------------------------------------------------------
   // Returns active-high indication for all three indicators of one port
   function [2:0] led_map;
      input [1:0] mode;
      input       link;
      input       act;
      input       spd;
      input       fdx;
      input       col;
      input       blink;
      reg         la;
      reg         link_act;
      begin
         la       = link & act;
         // Steady with link, flashing while traffic passes
         link_act = link & ~act | la & blink;
         case (mode)
            `PLIM_MODE0: begin
               led_map[0] = spd;
               led_map[1] = col;
               led_map[2] = link_act;
            end
            `PLIM_MODE2: begin
               led_map[0] = col;
               led_map[1] = la & ~spd;
               led_map[2] = la & spd;
            end
            `PLIM_MODE3: begin
               led_map[0] = spd;
               led_map[1] = col ? blink : fdx;
               led_map[2] = link_act;
            end
            default: begin
               led_map = 3'h0;                    // Mode 1 reserved
            end
         endcase
      end
   endfunction

   wire [PORTS-1:0] ind0_on;
   wire [PORTS-1:0] ind2_on;
   wire [PORTS-1:0] ind3_on;

   // One decode per port, gathered into active-high vectors
   genvar g;
   generate
      for (g = 0; g < PORTS; g = g + 1) begin : port_g
         wire [2:0] ind;
         assign ind = led_map(mode_reg, link_s[g], act_s[g], spd_s[g],
                              fdx_s[g], col_s[g], blink_reg);
         assign ind0_on[g] = ind[0];
         assign ind2_on[g] = ind[1];
         assign ind3_on[g] = ind[2];
      end
   endgenerate

   // ----------------------------------------------------------------
   // Pin drivers
   // ----------------------------------------------------------------
   // Pins stay released until the mode is latched, so the board
   // strap network alone sets the pin level while reset is held
   always @(posedge clk_in) begin
      if (!rst_b_in || state_reg != ST_RUN) begin
         port_indicator_zero_out  <= {PORTS{`PLIM_LED_OFF}};
         port_indicator_two_out   <= {PORTS{`PLIM_LED_OFF}};
         port_indicator_three_out <= {PORTS{`PLIM_LED_OFF}};
         port_indicator_oe_out    <= {PORTS{1'h0}};
      end else begin
         port_indicator_zero_out  <= ~ind0_on;
         port_indicator_two_out   <= ~ind2_on;
         port_indicator_three_out <= ~ind3_on;
         port_indicator_oe_out    <= {PORTS{1'h1}};
      end
   end

   // Captured mode for observation
   always @(posedge clk_in) begin
      if (!rst_b_in)
         indicator_mode_out <= `PLIM_MODE_RST;
      else
         indicator_mode_out <= mode_reg;
   end

endmodule

// *** tb/plim_port_led_sva.sv ***
/* Checker on the indicator block ports, port 0 mapping per mode.
   Assumes binding to plim_port_led with the same PORTS value. */
`timescale 1ns/1ns
module plim_port_led_sva #(parameter PORTS = 8) (
   input wire             clk_in,
   input wire             rst_b_in,
   input wire [1:0]       indicator_mode_strap_in,
   input wire [PORTS-1:0] link_up_in, activity_in, speed_100_in,
   input wire [PORTS-1:0] full_duplex_in, collision_in,
   input wire [PORTS-1:0] port_indicator_zero_out, port_indicator_two_out,
   input wire [PORTS-1:0] port_indicator_three_out, port_indicator_oe_out,
   input wire [1:0]       indicator_mode_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   wire [1:0] md = indicator_mode_out;
   // Port 0 driven long enough for synced status to arrive
   sequence settled;
      port_indicator_oe_out[0] && $past(port_indicator_oe_out[0], 3);
   endsequence
   mode_capture_a: assert property ($rose(rst_b_in) |-> ##3
      md == $past(indicator_mode_strap_in, 3)) else $error("bad mode");
   drive_on_a: assert property ($rose(rst_b_in) |-> ##4
      port_indicator_oe_out == {PORTS{1'b1}}) else $error("not driven");
   col_zero_a: assert property (settled ##0 md == 2'h2 |->
      port_indicator_zero_out[0] == !$past(collision_in[0], 3))
      else $error("ind0 collision");
   act10_two_a: assert property (settled ##0 md == 2'h2 |->
      port_indicator_two_out[0] == !$past(link_up_in[0] & activity_in[0]
      & ~speed_100_in[0], 3)) else $error("ind2 activity");
   duplex_two_a: assert property (settled ##0
      (md == 2'h3 && !$past(collision_in[0], 3)) |->
      port_indicator_two_out[0] == !$past(full_duplex_in[0], 3))
      else $error("ind2 duplex");
   link_three_a: assert property (settled ##0
      (md[0] == md[1] && !$past(activity_in[0], 3)) |->
      port_indicator_three_out[0] == !$past(link_up_in[0], 3))
      else $error("ind3 link");
   speed_zero_a: assert property (settled ##0 md[0] == md[1] |->
      port_indicator_zero_out[0] == !$past(speed_100_in[0], 3))
      else $error("ind0 speed");
   col_two_a: assert property (settled ##0 md == 2'h0 |->
      port_indicator_two_out[0] == !$past(collision_in[0], 3))
      else $error("ind2 collision");
   mode_hold_a: assert property (port_indicator_oe_out[0] |=>
      $stable(md)) else $error("mode moved");
endmodule

bind plim_port_led plim_port_led_sva #(.PORTS(PORTS)) u_sva (
   .clk_in(clk_in), .rst_b_in(rst_b_in),
   .indicator_mode_strap_in(indicator_mode_strap_in),
   .link_up_in(link_up_in), .activity_in(activity_in),
   .speed_100_in(speed_100_in), .full_duplex_in(full_duplex_in),
   .collision_in(collision_in),
   .port_indicator_zero_out(port_indicator_zero_out),
   .port_indicator_two_out(port_indicator_two_out),
   .port_indicator_three_out(port_indicator_three_out),
   .port_indicator_oe_out(port_indicator_oe_out),
   .indicator_mode_out(indicator_mode_out));

// *** tb/plim_led_bank.sv ***
/* External indicator lamps for three indicators on eight ports.
   Assumes each lamp sinks into its pin, lit when the pin is low. */
`timescale 1ns/1ns
module plim_led_bank (
   input  wire [23:0] pin_in,
   input  wire [7:0]  oe_in,
   output wire [23:0] lit_out
);
   // Released pins float and leave the lamps dark
   assign lit_out = {3{oe_in}} & ~pin_in;
endmodule

// *** tb/plim_port_led_tb_top.sv ***
/* Bench for the indicator block: modes 0 to 3 and strap hold.
   Assumes the checker binds itself to the design. */
`timescale 1ns/1ns
module plim_port_led_tb_top;
   logic clk_in = 0, rst_b_in = 0, on = 0, off = 0;
   logic [1:0] strap = 0, mode;
   logic [7:0] link = 0, act = 0, spd = 0, fdx = 0, col = 0, z, t, h, oe;
   logic [23:0] lit;
   int bad_count = 0, tests_run = 0;
   plim_port_led #(.BLINK_CYC(4)) DUT (.clk_in(clk_in),
      .rst_b_in(rst_b_in), .indicator_mode_strap_in(strap),
      .link_up_in(link), .activity_in(act), .speed_100_in(spd),
      .full_duplex_in(fdx), .collision_in(col),
      .port_indicator_zero_out(z), .port_indicator_two_out(t),
      .port_indicator_three_out(h), .port_indicator_oe_out(oe),
      .indicator_mode_out(mode));
   plim_led_bank LEDS (.pin_in({h, t, z}), .oe_in(oe), .lit_out(lit));
   initial forever #50 clk_in = ~clk_in;
   task cmp(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Reset for four cycles with the strap held across release
   task boot(input logic [1:0] m);
      @(posedge clk_in);
      rst_b_in <= 0;
      strap <= m;
      repeat (4) @(posedge clk_in);
      rst_b_in <= 1;
      repeat (8) @(negedge clk_in);
      cmp({6'h00, mode}, {6'h00, m});
      cmp(oe, 8'hFF);
   endtask
   task put(input logic [7:0] l, a, s, f, c);
      @(posedge clk_in);
      {link, act, spd, fdx, col} <= {l, a, s, f, c};
      repeat (5) @(negedge clk_in);
   endtask
   task t_mode0;
      boot(2'h0);
      put(8'hF0, 8'h00, 8'hCC, 8'hAA, 8'h0F);
      cmp(lit[7:0], 8'hCC);
      cmp(lit[15:8], 8'h0F);
      cmp(lit[23:16], 8'hF0);
   endtask
   task t_mode2;
      boot(2'h2);
      put(8'hF0, 8'hFF, 8'hCC, 8'h00, 8'h3C);
      cmp(lit[7:0], 8'h3C);
      cmp(lit[15:8], 8'h30);
      cmp(lit[23:16], 8'hC0);
   endtask
   // Strap moved after capture; collision on port 0 must blink
   task t_mode3;
      boot(2'h3);
      put(8'hF0, 8'h00, 8'hCC, 8'hAA, 8'h00);
      cmp(lit[7:0], 8'hCC);
      cmp(lit[15:8], 8'hAA);
      cmp(lit[23:16], 8'hF0);
      @(posedge clk_in);
      strap <= 2'h0;
      put(8'hF0, 8'h00, 8'hCC, 8'hAA, 8'h01);
      repeat (16) begin
         @(negedge clk_in);
         on = on | lit[8];
         off = off | !lit[8];
      end
      cmp({6'h00, on, off}, 8'h03);
      cmp({6'h00, mode}, 8'h03);
   endtask
   task t_mode1;
      boot(2'h1);
      put(8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF);
      cmp(lit[7:0] | lit[15:8] | lit[23:16], 8'h00);
   endtask
   initial begin
      t_mode0;
      t_mode2;
      t_mode3;
      t_mode1;
      end_of_test;
   end
   // Run needs about 100 cycles; cut off at 500
   initial begin
      #50000;
      bad_count++;
      end_of_test;
   end
endmodule
